// ==== src/tcs_timer_channel.sv ====
/*
 * Top of one timer channel: APB mode, data, count, trigger and status registers,
 * operation clock and count clock selection, and a down-counting interval timer.
 * Assumes the four prescaled clocks arrive as one-cycle tick pulses on CLK_SYS
 * from the unit prescaler, and that the input pin is asynchronous.
 */
// Overview of operation
// - Field 15:14 picks operation clock: 00 ck0, 01 ck2, 10 ck1, 11 ck3.
// - Prescaled clocks 2 and 3 selectable only on channels 1 and 3.
// - Count-clock source bit 0 makes the count clock equal the operation clock.
// - Count-clock source bit 1 counts valid edges on the channel input pin.
// - Count clock drives counter, output control and interrupt generation.
// - Operation clock feeds the input edge detector and its sampling.
// - Start trigger code 000 allows only software start.
// - Mode 000 with low bit 0: interval timer, no interrupt or toggle at start.
`timescale 1ns/1ps
module tcs_timer_channel
   import tcs_pkg::*;
#(
   parameter int CHANNEL_ID = 0
)
(
   input  wire logic        CLK_SYS,
   input  wire logic        RST,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic [31:0]      PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   input  wire logic        PRESCALED_CLOCK_0,
   input  wire logic        PRESCALED_CLOCK_1,
   input  wire logic        PRESCALED_CLOCK_2,
   input  wire logic        PRESCALED_CLOCK_3,
   input  wire logic        CHANNEL_INPUT_PIN,
   output logic             TIMER_OUT,
   output logic             TIMER_IRQ
);

   // Clocks 2 and 3 reach every channel but can be selected only on the channels that may use them
   localparam bit HAS_HI_CLKS = (CHANNEL_ID == 1) || (CHANNEL_ID == 3);

   logic [15:0] mode_q;
   logic [15:0] data_q;
   logic [15:0] count_q;
   logic        running_q;
   logic        out_q;
   logic        irq_q;
   logic [31:0] prdata_q;
   logic        pready_q;
   logic        pslverr_q;
   logic        op_tick;
   logic        count_tick;
   logic        edge_pulse;
   logic        sw_start;
   logic        sw_stop;
   logic        start_go;
   logic        wr_en;
   logic [1:0]  op_sel;
   logic [2:0]  start_sel;

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   function automatic logic addr_mapped(input logic [7:0] a);
      addr_mapped = (a == OFS_MODE) || (a == OFS_DATA) || (a == OFS_COUNT) ||
                    (a == OFS_TRIG) || (a == OFS_STATUS);
   endfunction

   assign wr_en     = PSEL && PENABLE && pready_q && PWRITE && addr_mapped(PADDR);
   assign sw_start  = wr_en && (PADDR == OFS_TRIG) && PWDATA[POS_TRG_START];
   assign sw_stop   = wr_en && (PADDR == OFS_TRIG) && PWDATA[POS_TRG_STOP];
   assign op_sel    = {mode_q[POS_CKS_HI], mode_q[POS_CKS_LO]};
   assign start_sel = mode_q[POS_STS +: 3];

   // ----------------------------------------
   // APB slave: answer ready in the access phase, one wait-free access
   // ----------------------------------------
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= RD_ZERO;
      end else begin
         pready_q  <= PSEL && !PENABLE;
         pslverr_q <= PSEL && !PENABLE && !addr_mapped(PADDR);
         if (PSEL && !PENABLE && !PWRITE) begin
            unique case (PADDR)
               OFS_MODE:   prdata_q <= {16'h0000, mode_q};
               OFS_DATA:   prdata_q <= {16'h0000, data_q};
               OFS_COUNT:  prdata_q <= {16'h0000, count_q};
               OFS_STATUS: prdata_q <= {30'h0000_0000, out_q, running_q};
               default:    prdata_q <= RD_ZERO;
            endcase
         end
      end
   end

   assign PRDATA  = prdata_q;
   assign PREADY  = pready_q;
   assign PSLVERR = pslverr_q;

   // ----------------------------------------
   // Mode and data registers
   // ----------------------------------------
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         mode_q <= MODE_RESET;
         data_q <= DATA_RESET;
      end else if (wr_en) begin
         if (PADDR == OFS_MODE) begin
            mode_q                <= PWDATA[15:0] & MODE_MASK;
            mode_q[POS_CKS_LO]    <= PWDATA[POS_CKS_LO] && HAS_HI_CLKS;
         end
         if (PADDR == OFS_DATA) begin
            data_q <= PWDATA[15:0];
         end
      end
   end

   // ----------------------------------------
   // Operation clock and count clock selection
   // ----------------------------------------
   always_comb begin
      unique case (op_sel)
         SEL_CK0: op_tick = PRESCALED_CLOCK_0;
         SEL_CK2: op_tick = PRESCALED_CLOCK_2;
         SEL_CK1: op_tick = PRESCALED_CLOCK_1;
         SEL_CK3: op_tick = PRESCALED_CLOCK_3;
      endcase
   end

   tcs_input_edge tcs_input_edge_i (
      .clk        (CLK_SYS),
      .rst        (RST),
      .pin        (CHANNEL_INPUT_PIN),
      .op_tick    (op_tick),
      .edge_sel   (mode_q[POS_CIS +: 2]),
      .edge_pulse (edge_pulse)
   );

   // Edge counting stays tied to the operation clock, so slow clocks cap the input rate
   assign count_tick = mode_q[POS_CCS] ? edge_pulse : op_tick;

   // Codes 001 and 010 add pin edges as start sources; master start is not wired here
   always_comb begin
      unique case (start_sel)
         STS_SOFT: start_go = sw_start;
         STS_EDGE: start_go = sw_start || edge_pulse;
         STS_BOTH: start_go = sw_start || edge_pulse;
         default:  start_go = sw_start;
      endcase
   end

   // ----------------------------------------
   // Counter, output control and interrupt pulse
   // ----------------------------------------
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         running_q <= 1'b0;
         count_q   <= DATA_RESET;
         out_q     <= 1'b0;
         irq_q     <= 1'b0;
      end else begin
         irq_q <= 1'b0;
         if (sw_stop) begin
            running_q <= 1'b0;
         end else if (start_go) begin
            running_q <= 1'b1;
            count_q   <= data_q;
            if (mode_q[POS_MD]) begin
               irq_q <= 1'b1;
               out_q <= !out_q;
            end
         end else if (running_q && count_tick) begin
            if (count_q == DATA_RESET) begin
               count_q <= data_q;
               irq_q   <= 1'b1;
               out_q   <= !out_q;
            end else begin
               count_q <= count_q - 16'h0001;
            end
         end
      end
   end

   assign TIMER_OUT = out_q;
   assign TIMER_IRQ = irq_q;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_opclk_ck2_pick: assert property (@(posedge CLK_SYS) disable iff (RST)
      (op_sel == SEL_CK2) |-> (op_tick == PRESCALED_CLOCK_2))
      else $error("operation clock select 01 does not pick prescaled clock 2");

   a_hi_clk_block: assert property (@(posedge CLK_SYS) disable iff (RST)
      !HAS_HI_CLKS |-> !mode_q[POS_CKS_LO])
      else $error("prescaled clock 2 or 3 selectable on this channel");

   a_count_op_tick: assert property (@(posedge CLK_SYS) disable iff (RST)
      (!mode_q[POS_CCS] && op_tick && running_q && !start_go && !sw_stop && count_q != DATA_RESET)
      |=> (count_q == $past(count_q) - 16'h0001))
      else $error("counter did not step on the operation clock");

   a_edge_only_count: assert property (@(posedge CLK_SYS) disable iff (RST)
      (mode_q[POS_CCS] && !edge_pulse && !start_go) |=> $stable(count_q))
      else $error("counter moved without a pin edge in edge count mode");

   a_irq_has_cause: assert property (@(posedge CLK_SYS) disable iff (RST)
      TIMER_IRQ |-> $past(start_go || (running_q && count_tick && count_q == DATA_RESET)))
      else $error("interrupt pulse without a count clock cause");

   a_reserved_bits: assert property (@(posedge CLK_SYS) disable iff (RST)
      (mode_q & ~MODE_MASK) == 16'h0000)
      else $error("reserved mode bits are not zero");

   a_soft_start: assert property (@(posedge CLK_SYS) disable iff (RST)
      (start_sel == STS_SOFT && !sw_start && !running_q && !sw_stop) |=> !running_q)
      else $error("channel started without a software trigger");

   a_quiet_start: assert property (@(posedge CLK_SYS) disable iff (RST)
      (start_go && !sw_stop && !mode_q[POS_MD]) |=> (!TIMER_IRQ && $stable(TIMER_OUT)))
      else $error("interrupt or output change at counting start");

endmodule

// ==== src/tcs_pkg.sv ====
/*
 * Package for the timer channel with clock-source selection: register offsets,
 * field positions, reset values and field encodings.
 * Assumes a 32-bit APB register port and a 20 MHz system clock.
 */
package tcs_pkg;

   // ----------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------
   localparam logic [7:0]  OFS_MODE      = 8'h00;
   localparam logic [7:0]  OFS_DATA      = 8'h04;
   localparam logic [7:0]  OFS_COUNT     = 8'h08;
   localparam logic [7:0]  OFS_TRIG      = 8'h0C;
   localparam logic [7:0]  OFS_STATUS    = 8'h10;

   // ----------------------------------------
   // Mode register fields
   // ----------------------------------------
   localparam int          MODE_W        = 16;
   localparam logic [15:0] MODE_MASK     = 16'hD7CF;
   localparam logic [15:0] MODE_RESET    = 16'h0000;
   localparam logic [15:0] DATA_RESET    = 16'h0000;
   localparam int          POS_CKS_LO    = 14;
   localparam int          POS_CKS_HI    = 15;
   localparam int          POS_CCS       = 12;
   localparam int          POS_STS       = 8;
   localparam int          POS_CIS       = 6;
   localparam int          POS_MD        = 0;
   localparam int          POS_TRG_START = 0;
   localparam int          POS_TRG_STOP  = 1;

   // Operation clock select: {op_clock_sel_hi, op_clock_sel_lo}
   localparam logic [1:0]  SEL_CK0       = 2'b00;
   localparam logic [1:0]  SEL_CK2       = 2'b01;
   localparam logic [1:0]  SEL_CK1       = 2'b10;
   localparam logic [1:0]  SEL_CK3       = 2'b11;

   // Start trigger select
   localparam logic [2:0]  STS_SOFT      = 3'b000;
   localparam logic [2:0]  STS_EDGE      = 3'b001;
   localparam logic [2:0]  STS_BOTH      = 3'b010;

   // Input edge select
   localparam logic [1:0]  CIS_FALL      = 2'b00;
   localparam logic [1:0]  CIS_RISE      = 2'b01;

   localparam logic [31:0] RD_ZERO       = 32'h0000_0000;

endpackage

// ==== src/tcs_input_edge.sv ====
/*
 * Input edge detector of the timer channel: synchronises the channel input pin
 * and reports valid edges, sampled on the channel's operation clock tick.
 * Assumes the pin is asynchronous to CLK_SYS and op_tick is a one-cycle pulse.
 */
`timescale 1ns/1ps
module tcs_input_edge
   import tcs_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       pin,
   input  wire logic       op_tick,
   input  wire logic [1:0] edge_sel,
   output logic            edge_pulse
);

   logic [2:0] sync_q;
   logic       level_q;
   logic       sampled_q;
   logic       rise;
   logic       fall;

   // ----------------------------------------
   // Three-stage synchroniser; stage two and three must agree
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         sync_q  <= 3'b000;
         level_q <= 1'b0;
      end else begin
         sync_q  <= {sync_q[1:0], pin};
         if (sync_q[1] == sync_q[2]) begin
            level_q <= sync_q[2];
         end
      end
   end

   // ----------------------------------------
   // Edge sampling on the operation clock
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         sampled_q <= 1'b0;
      end else if (op_tick) begin
         sampled_q <= level_q;
      end
   end

   assign rise = op_tick && level_q && !sampled_q;
   assign fall = op_tick && !level_q && sampled_q;

   always_comb begin
      unique case (edge_sel)
         CIS_FALL: edge_pulse = fall;
         CIS_RISE: edge_pulse = rise;
         default:  edge_pulse = rise || fall;
      endcase
   end

   a_edge_on_tick: assert property (@(posedge clk) disable iff (rst) edge_pulse |-> op_tick)
      else $error("input edge reported outside an operation clock tick");

endmodule

// ==== verification/tcs_timer_channel_tb_top.sv ====
/*
 * Self-checking bench for the timer channel: APB register access, operation clock
 * selection, count clock source and the interval timer.
 * Assumes the design answers APB itself and the prescaled clocks are tick pulses.
 */
`timescale 1ns/1ps
module timer_channel_clock_select_tb_top;
   import tcs_pkg::*;
   // ----------------------------------------
   // Stimulus and observation
   // ----------------------------------------
   logic        clk = 0, rst = 1, penable = 0, pwrite = 0, pin = 0;
   logic [1:0]  psel = 2'h0;
   wire  [1:0]  pready, pslverr, tout, irq;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   wire  [31:0] prdata [2];
   logic [3:0]  ck = 4'h0;
   int          bad_count = 0, tests_run = 0, irq_n = 0;
   int          map [4] = '{0, 2, 1, 3};
   always #25 clk = ~clk;
   always @(posedge clk) if (irq[0] === 1'b1) irq_n++;
   // Channel 0 cannot select clocks 2 and 3; channel 1 offers all four
   for (genvar c = 0; c < 2; c++) begin : g_ch
      tcs_timer_channel #(.CHANNEL_ID(c)) tcs_timer_channel_i (
         .CLK_SYS(clk), .RST(rst), .PSEL(psel[c]), .PENABLE(penable), .PWRITE(pwrite),
         .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata[c]), .PREADY(pready[c]),
         .PSLVERR(pslverr[c]), .PRESCALED_CLOCK_0(ck[0]), .PRESCALED_CLOCK_1(ck[1]),
         .PRESCALED_CLOCK_2(ck[2]), .PRESCALED_CLOCK_3(ck[3]), .CHANNEL_INPUT_PIN(pin),
         .TIMER_OUT(tout[c]), .TIMER_IRQ(irq[c]));
   end
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Wait for pready without assuming a latency; pre-edge values are sampled
   task automatic apb(input int c, input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      @(posedge clk);
      psel[c] <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // Only the watchdog ends a wait that never sees pready
      do begin @(posedge clk); end while (pready[c] !== 1'b1);
      r = prdata[c];
      e = pslverr[c];
      psel[c] <= 1'b0; penable <= 1'b0;
   endtask
   task automatic wr(input int c, input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(c, 1'b1, a, d, r, e);
   endtask
   task automatic rd_chk(input int c, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] r;
      logic        e;
      apb(c, 1'b0, a, 32'h0000_0000, r, e);
      chk(r, exp);
   endtask
   task automatic tick(input int k);
      @(posedge clk) ck[k] <= 1'b1;
      @(posedge clk) ck[k] <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_regs();
      logic [31:0] r;
      logic        e;
      rd_chk(0, OFS_MODE, 32'h0000_0000);
      apb(0, 1'b0, 8'h14, 32'h0000_0000, r, e);
      chk({31'h0, e}, 32'h0000_0001);
      wr(0, OFS_MODE, 32'hFFFF_FFFF);
      rd_chk(0, OFS_MODE, 32'h0000_97CF);
      wr(1, OFS_MODE, 32'hFFFF_FFFF);
      rd_chk(1, OFS_MODE, 32'h0000_D7CF);
      $display("test regs done");
   endtask
   // Only the clock named by the field may move the counter
   task automatic t_opclk();
      for (int s = 0; s < 4; s++) begin
         wr(1, OFS_MODE, 32'(s) << POS_CKS_LO);
         wr(1, OFS_DATA, 32'h0000_0002);
         wr(1, OFS_TRIG, 32'h0000_0001);
         for (int k = 0; k < 4; k++) if (k != map[s]) tick(k);
         rd_chk(1, OFS_COUNT, 32'h0000_0002);
         tick(map[s]);
         rd_chk(1, OFS_COUNT, 32'h0000_0001);
         // Underflow on the selected clock reloads and toggles the output once per pass
         tick(map[s]);
         tick(map[s]);
         chk({31'h0, tout[1]}, 32'((s + 1) % 2));
         rd_chk(1, OFS_COUNT, 32'h0000_0002);
         wr(1, OFS_TRIG, 32'h0000_0002);
      end
      $display("test opclk done");
   endtask
   task automatic t_interval();
      int n;
      wr(0, OFS_MODE, 32'h0000_0000);
      wr(0, OFS_DATA, 32'h0000_0001);
      n = irq_n;
      wr(0, OFS_TRIG, 32'h0000_0001);
      repeat (3) @(posedge clk);
      chk(32'(irq_n - n), 32'h0000_0000);
      chk({31'h0, tout[0]}, 32'h0000_0000);
      tick(0);
      tick(0);
      chk(32'(irq_n - n), 32'h0000_0001);
      rd_chk(0, OFS_STATUS, 32'h0000_0003);
      // Start with low mode bit set does interrupt and toggle, unlike code 0
      wr(0, OFS_MODE, 32'h0000_0001);
      wr(0, OFS_TRIG, 32'h0000_0001);
      repeat (3) @(posedge clk);
      chk(32'(irq_n - n), 32'h0000_0002);
      chk({31'h0, tout[0]}, 32'h0000_0000);
      $display("test interval done");
   endtask
   task automatic t_pin();
      wr(0, OFS_TRIG, 32'h0000_0002);
      wr(0, OFS_DATA, 32'h0000_0002);
      wr(0, OFS_MODE, (32'h1 << POS_CCS) | (32'(CIS_RISE) << POS_CIS));
      @(posedge clk) pin <= 1'b1;
      repeat (6) @(posedge clk);
      tick(0);
      rd_chk(0, OFS_STATUS, 32'h0000_0000);
      wr(0, OFS_TRIG, 32'h0000_0001);
      @(posedge clk) pin <= 1'b0;
      repeat (6) @(posedge clk);
      tick(0);
      rd_chk(0, OFS_COUNT, 32'h0000_0002);
      @(posedge clk) pin <= 1'b1;
      repeat (6) @(posedge clk);
      rd_chk(0, OFS_COUNT, 32'h0000_0002);
      tick(0);
      rd_chk(0, OFS_COUNT, 32'h0000_0001);
      $display("test pin done");
   endtask
   // ----------------------------------------
   // Sequence and verdict
   // ----------------------------------------
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_regs();
      t_opclk();
      t_interval();
      t_pin();
      conclude();
   end
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      conclude();
   end
endmodule
